// [adcr_defs.svh]
/*
  Constants of the converter control block: register offsets, field positions,
  reset value, timing figures, and cycle counts for the conversion, sync and busy-maximum times.
  Assumes the block clock runs at ADCR_MCLK_MHZ.
*/
`ifndef ADCR_DEFS_SVH
`define ADCR_DEFS_SVH

// Register byte offsets
`define ADCR_OFS_CTRL 4'h0
`define ADCR_OFS_STATUS 4'h4
`define ADCR_OFS_RESULT 4'h8

// Control field positions and reset value
`define ADCR_CTRL_SER_BIT 0
`define ADCR_CTRL_EXT_BIT 1
`define ADCR_CTRL_RDC_BIT 2
`define ADCR_CTRL_DIV_LSB 4
`define ADCR_CTRL_RESET 5'h00

// Status field positions
`define ADCR_STAT_BUSY_BIT 0
`define ADCR_STAT_SYNC_BIT 1

// Clock rate and unit scale
`define ADCR_MCLK_MHZ 40
`define ADCR_NS_PER_US 1000

// Conversion timing in ns
`define ADCR_T_CONV_NS 1250
`define ADCR_T_RDC_SYNC_NS 560
`define ADCR_T_RAC_SYNC_NS 1310
`define ADCR_T_BUSY_MAX_NS 1450
`define ADCR_T_BUSY_RAC0_NS 2250
`define ADCR_T_BUSY_RAC1_NS 3000
`define ADCR_T_BUSY_RAC2_NS 4400
`define ADCR_T_BUSY_RAC3_NS 7300

// Serial clock minima in ns per divide code
`define ADCR_T_LEAD0_NS 3
`define ADCR_T_LEAD_NS 20
`define ADCR_T_HIGH0_NS 15
`define ADCR_T_HIGH1_NS 30
`define ADCR_T_HIGH2_NS 60
`define ADCR_T_HIGH3_NS 120
`define ADCR_T_LOW0_NS 10
`define ADCR_T_LOW1_NS 25
`define ADCR_T_LOW2_NS 55
`define ADCR_T_LOW3_NS 115
`define ADCR_T_TAIL0_NS 5
`define ADCR_T_TAIL1_NS 7
`define ADCR_T_TAIL2_NS 35
`define ADCR_T_TAIL3_NS 90

// Cycle counts: longest and typical times round down
`define ADCR_DN(ns) (((ns) * `ADCR_MCLK_MHZ) / `ADCR_NS_PER_US)
`define ADCR_CONV_CYC `ADCR_DN(`ADCR_T_CONV_NS)
`define ADCR_RDC_SYNC_CYC `ADCR_DN(`ADCR_T_RDC_SYNC_NS)
`define ADCR_RAC_SYNC_CYC `ADCR_DN(`ADCR_T_RAC_SYNC_NS)
`define ADCR_BUSY_MAX_CYC `ADCR_DN(`ADCR_T_BUSY_MAX_NS)

`endif

// [adcr_pkg.sv]
/*
  Types of the converter control block.
  Assumes adcr_defs.svh supplies the numeric constants.
*/
package adcr_pkg;

  typedef struct packed {
    logic [1:0] clock_divide_select;
    logic read_timing_select;
    logic clock_source_select;
    logic serial_parallel_select;
  } adcr_ctrl_type;

  typedef enum logic [2:0] {
    SER_IDLE,
    SER_LEAD,
    SER_HIGH,
    SER_LOW,
    SER_TAIL
  } adcr_ser_state_type;

endpackage

// [adcr_core.sv]
/*
  Conversion control and result readout for a 16-bit SAR converter: busy
  sequencing, parallel bus, master and slave serial readout, Wishbone slave.
  Assumes all inputs are synchronous to i_mclk at 40 MHz and that the SAR
  array presents its result on i_sample_data by the end of conversion.
*/
`include "adcr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// Function
// - Busy rises within 35 ns of convert-start falling.
// - Outside master read-after-convert, busy lasts at most 1.45 us.
// - Conversion ends within 1.45 us; busy falls 10 ns or more later.
// - Parallel result valid within 1.41 us of convert-start falling.
// - Parallel result valid at least 20 ns before busy falls.
// - Master read-during-convert: frame sync about 560 ns after start, previous result.
// - Master read-after-convert: frame sync about 1.31 us after start, new result.
// - Divide code 00..11 gives serial clock periods of at least 30/60/120/240 ns.
// - Read-after-convert busy at most 2.25/3.00/4.40/7.30 us per divide code.
// - Frame sync leads first serial clock edge by at least 3 ns (code 00) or 20 ns.
// - Frame sync drops at least 5 ns after the last serial clock edge.
// - Read-after-convert busy falls about 25 ns after frame sync drops.
// - Chip select enables or floats sync, clock and data outputs.
// - Slave clock period 50 ns (two i_mclk cycles) or more; data updates after each active edge.
// - Each result is one 16-bit word, parallel or serial.
// - Result readable as soon as its conversion ends, no pipeline.
// - Divide select acts only in master read-after-convert mode.
module adcr_core #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Conversion control
  input wire logic i_convert_start_n,
  input wire logic i_cs_n,
  input wire logic [DATA_W-1:0] i_sample_data,
  output logic o_busy,
  // Parallel bus
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe,
  // Serial port
  input wire logic i_serial_data_clock,
  output logic o_serial_data_clock,
  output logic o_serial_data_clock_oe,
  output logic o_frame_sync,
  output logic o_frame_sync_oe,
  output logic o_serial_data_out,
  output logic o_serial_data_out_oe
);

  localparam int BIT_W = $clog2(DATA_W + 1);
  localparam int C_CONV = `ADCR_CONV_CYC;
  localparam int C_RDC = `ADCR_RDC_SYNC_CYC;
  localparam int C_RAC = `ADCR_RAC_SYNC_CYC;
  localparam int C_BMAX = `ADCR_BUSY_MAX_CYC;

  initial begin
    if (DATA_W < 2 || DATA_W > 32) $error("adcr_core: DATA_W out of range");
    if (C_RAC <= C_CONV || C_RDC >= C_CONV) $error("adcr_core: sync timing");
  end

  function automatic logic [2:0] ns_up(input int ns);
    int c;
    c = (ns * `ADCR_MCLK_MHZ + `ADCR_NS_PER_US - 1) / `ADCR_NS_PER_US;
    if (c < 1) c = 1;
    return c[2:0];
  endfunction

  function automatic logic [2:0] half_cyc(input logic [1:0] div);
    logic [2:0] hi;
    logic [2:0] lo;
    hi = 3'h1;
    lo = 3'h1;
    unique case (div)
      2'h0: begin hi = ns_up(`ADCR_T_HIGH0_NS); lo = ns_up(`ADCR_T_LOW0_NS); end
      2'h1: begin hi = ns_up(`ADCR_T_HIGH1_NS); lo = ns_up(`ADCR_T_LOW1_NS); end
      2'h2: begin hi = ns_up(`ADCR_T_HIGH2_NS); lo = ns_up(`ADCR_T_LOW2_NS); end
      2'h3: begin hi = ns_up(`ADCR_T_HIGH3_NS); lo = ns_up(`ADCR_T_LOW3_NS); end
    endcase
    return (hi > lo) ? hi : lo;
  endfunction

  function automatic logic [2:0] tail_cyc(input logic [1:0] div);
    logic [2:0] t;
    t = 3'h1;
    unique case (div)
      2'h0: t = ns_up(`ADCR_T_TAIL0_NS);
      2'h1: t = ns_up(`ADCR_T_TAIL1_NS);
      2'h2: t = ns_up(`ADCR_T_TAIL2_NS);
      2'h3: t = ns_up(`ADCR_T_TAIL3_NS);
    endcase
    return t;
  endfunction

  adcr_pkg::adcr_ctrl_type ctrl_q;
  adcr_pkg::adcr_ser_state_type ser_q;
  logic start_n_q, busy_q, eoc_q, sync_q, sclk_q, sclk_d1_q, frame_done_q, ext_clk_q, ack_q;
  logic [7:0] cnt_q;
  logic [DATA_W-1:0] result_q;
  logic [DATA_W-1:0] shift_q;
  logic [2:0] tm_q;
  logic [BIT_W-1:0] bits_q;
  logic [31:0] rdat_q;
  logic start_fall, master, rac_master, slave, start_frame, wb_req;
  logic [1:0] div_eff;

  assign start_fall = start_n_q && !i_convert_start_n;
  assign master = ctrl_q.serial_parallel_select && !ctrl_q.clock_source_select;
  assign slave = ctrl_q.serial_parallel_select && ctrl_q.clock_source_select;
  assign rac_master = master && !ctrl_q.read_timing_select;
  assign div_eff = rac_master ? ctrl_q.clock_divide_select : 2'h0;
  assign start_frame = busy_q && master && ser_q == adcr_pkg::SER_IDLE &&
                       cnt_q == (rac_master ? 8'(C_RAC) : 8'(C_RDC));
  assign wb_req = i_wb_cyc && i_wb_stb;

  // Convert-start edge detection
  always_ff @(posedge i_mclk) begin
    if (i_rst) start_n_q <= 1'b1;
    else start_n_q <= i_convert_start_n;
  end

  // Busy flag and conversion timer; a start while busy is ignored
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (start_fall && !busy_q) begin
      busy_q <= 1'b1;
      cnt_q <= 8'h01;
    end else if (busy_q) begin
      if (cnt_q != 8'hFF) cnt_q <= cnt_q + 8'h01;
      if (rac_master ? frame_done_q : eoc_q) busy_q <= 1'b0;
    end
  end

  // End of conversion: result latched, readable at once
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      eoc_q <= 1'b0;
      result_q <= '0;
    end else begin
      eoc_q <= busy_q && cnt_q == 8'(C_CONV);
      if (busy_q && cnt_q == 8'(C_CONV)) result_q <= i_sample_data;
    end
  end

  // Master serial sequencer
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ser_q <= adcr_pkg::SER_IDLE;
      sync_q <= 1'b0;
      sclk_q <= 1'b0;
      frame_done_q <= 1'b0;
      tm_q <= 3'h0;
      bits_q <= '0;
    end else begin
      frame_done_q <= 1'b0;
      unique case (ser_q)
        adcr_pkg::SER_IDLE: begin
          if (start_frame) begin
            sync_q <= 1'b1;
            bits_q <= '0;
            tm_q <= (div_eff == 2'h0) ? ns_up(`ADCR_T_LEAD0_NS) - 3'h1 : ns_up(`ADCR_T_LEAD_NS) - 3'h1;
            ser_q <= adcr_pkg::SER_LEAD;
          end
        end
        adcr_pkg::SER_LEAD, adcr_pkg::SER_LOW: begin
          if (tm_q == 3'h0) begin
            sclk_q <= 1'b1;
            tm_q <= half_cyc(div_eff) - 3'h1;
            ser_q <= adcr_pkg::SER_HIGH;
          end else tm_q <= tm_q - 3'h1;
        end
        adcr_pkg::SER_HIGH: begin
          if (tm_q == 3'h0) begin
            sclk_q <= 1'b0;
            bits_q <= bits_q + BIT_W'(1);
            if (bits_q == BIT_W'(DATA_W - 1)) begin
              tm_q <= tail_cyc(div_eff) - 3'h1;
              ser_q <= adcr_pkg::SER_TAIL;
            end else begin
              tm_q <= half_cyc(div_eff) - 3'h1;
              ser_q <= adcr_pkg::SER_LOW;
            end
          end else tm_q <= tm_q - 3'h1;
        end
        adcr_pkg::SER_TAIL: begin
          if (tm_q == 3'h0) begin
            sync_q <= 1'b0;
            frame_done_q <= 1'b1;
            ser_q <= adcr_pkg::SER_IDLE;
          end else tm_q <= tm_q - 3'h1;
        end
      endcase
    end
  end

  // Output shift register, shared by master and slave readout
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      shift_q <= '0;
      ext_clk_q <= 1'b0;
    end else begin
      ext_clk_q <= i_serial_data_clock;
      if (start_frame) shift_q <= (cnt_q == 8'(C_CONV)) ? i_sample_data : result_q;
      else if (ser_q == adcr_pkg::SER_HIGH && tm_q == 3'h0) shift_q <= shift_q << 1;
      else if (slave && eoc_q) shift_q <= result_q;
      else if (slave && !i_cs_n && i_serial_data_clock && !ext_clk_q) shift_q <= shift_q << 1;
    end
  end

  // Pin drive; enables follow chip select directly
  assign o_busy = busy_q;
  assign o_data = result_q;
  assign o_data_oe = !ctrl_q.serial_parallel_select && !i_cs_n;
  assign o_frame_sync = sync_q;
  assign o_frame_sync_oe = master && !i_cs_n;
  assign o_serial_data_clock = sclk_q;
  assign o_serial_data_clock_oe = master && !i_cs_n;
  assign o_serial_data_out = shift_q[DATA_W-1];
  assign o_serial_data_out_oe = ctrl_q.serial_parallel_select && !i_cs_n;

  // Wishbone: ack one cycle after request, read data latched as ack rises, write at the ack edge
  always_ff @(posedge i_mclk) begin
    if (i_rst) ack_q <= 1'b0;
    else ack_q <= wb_req && !ack_q;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) ctrl_q <= `ADCR_CTRL_RESET;
    else if (wb_req && ack_q && i_wb_we && i_wb_sel[0] && i_wb_adr == `ADCR_OFS_CTRL) begin
      ctrl_q.serial_parallel_select <= i_wb_dat[`ADCR_CTRL_SER_BIT];
      ctrl_q.clock_source_select <= i_wb_dat[`ADCR_CTRL_EXT_BIT];
      ctrl_q.read_timing_select <= i_wb_dat[`ADCR_CTRL_RDC_BIT];
      ctrl_q.clock_divide_select <= i_wb_dat[`ADCR_CTRL_DIV_LSB +: 2];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) rdat_q <= 32'h0000_0000;
    else if (wb_req && !ack_q) begin
      rdat_q <= 32'h0000_0000;
      unique case (i_wb_adr)
        `ADCR_OFS_CTRL: begin
          rdat_q[`ADCR_CTRL_SER_BIT] <= ctrl_q.serial_parallel_select;
          rdat_q[`ADCR_CTRL_EXT_BIT] <= ctrl_q.clock_source_select;
          rdat_q[`ADCR_CTRL_RDC_BIT] <= ctrl_q.read_timing_select;
          rdat_q[`ADCR_CTRL_DIV_LSB +: 2] <= ctrl_q.clock_divide_select;
        end
        `ADCR_OFS_STATUS: begin
          rdat_q[`ADCR_STAT_BUSY_BIT] <= busy_q;
          rdat_q[`ADCR_STAT_SYNC_BIT] <= sync_q;
        end
        `ADCR_OFS_RESULT: rdat_q[DATA_W-1:0] <= result_q;
        default: rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  // Checks
  logic [8:0] busy_len_q;
  logic [BIT_W-1:0] edges_q;
  int busy_rac_max;

  always_ff @(posedge i_mclk) begin
    if (i_rst || !busy_q) busy_len_q <= 9'h000;
    else if (busy_len_q != 9'h1FF) busy_len_q <= busy_len_q + 9'h001;
  end

  always_ff @(posedge i_mclk) begin
    sclk_d1_q <= sclk_q;
    if (i_rst || start_frame) edges_q <= '0;
    else if (sync_q && sclk_q && !sclk_d1_q) edges_q <= edges_q + BIT_W'(1);
  end

  assign busy_rac_max = (ctrl_q.clock_divide_select == 2'h0) ? `ADCR_DN(`ADCR_T_BUSY_RAC0_NS) :
                        (ctrl_q.clock_divide_select == 2'h1) ? `ADCR_DN(`ADCR_T_BUSY_RAC1_NS) :
                        (ctrl_q.clock_divide_select == 2'h2) ? `ADCR_DN(`ADCR_T_BUSY_RAC2_NS) :
                        `ADCR_DN(`ADCR_T_BUSY_RAC3_NS);

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  a_busy_rise_delay: assert property (start_fall && !busy_q |=> busy_q)
    else $error("busy did not rise one cycle after convert start");
  a_busy_width_max: assert property (busy_q && !rac_master |-> int'(busy_len_q) < C_BMAX)
    else $error("busy too long outside read-after-convert");
  a_conv_end_time: assert property ($rose(busy_q) |-> ##C_CONV eoc_q)
    else $error("conversion did not end on time");
  a_data_before_busy: assert property ($fell(busy_q) && !rac_master |->
    $past(eoc_q) && result_q == $past(i_sample_data, 2))
    else $error("parallel result not valid before busy fell");
  a_rdc_sync_time: assert property ($rose(busy_q) && master && ctrl_q.read_timing_select |->
    ##C_RDC $rose(sync_q))
    else $error("read-during-convert frame sync late or early");
  a_rac_sync_time: assert property ($rose(busy_q) && rac_master |-> ##C_RAC $rose(sync_q))
    else $error("read-after-convert frame sync late or early");
  a_rac_busy_max: assert property (busy_q && rac_master |-> int'(busy_len_q) < busy_rac_max)
    else $error("busy too long in read-after-convert");
  a_sync_lead_edge: assert property ($rose(sync_q) |-> !sclk_q)
    else $error("serial clock rose with frame sync");
  a_sync_tail_gap: assert property ($fell(sync_q) |-> !sclk_q && !$past(sclk_q))
    else $error("frame sync dropped too soon after last clock edge");
  a_busy_after_sync: assert property ($fell(sync_q) && rac_master |-> ##1 $fell(busy_q))
    else $error("busy did not fall one cycle after frame sync");
  a_cs_float_all: assert property (i_cs_n |->
    !o_frame_sync_oe && !o_serial_data_clock_oe && !o_serial_data_out_oe)
    else $error("serial outputs driven with chip select high");
  a_frame_bit_count: assert property ($fell(sync_q) |-> int'(edges_q) == DATA_W)
    else $error("frame did not carry one full word");

endmodule

`default_nettype wire

// [adcr_host_model.sv]
/*
  Host controller model: convert strobe, slave serial clock and a capture of
  master serial frames in clock-cycle stamps.
  Assumes the bench resolves sync, clock and data wires from the enables.
*/
`timescale 1ns/1ps
`default_nettype none

module adcr_host_model (
  // Clock
  input wire logic i_mclk,
  // Serial wires as seen by the host
  input wire logic i_sync,
  input wire logic i_sclk,
  input wire logic i_sdo,
  // Host drives
  output logic o_convert_start_n,
  output logic o_clk
);
  int cyc = 0;
  int t_sync = 0;
  int t_fall = 0;
  int t_rise = -1;
  int lead = 0;
  int per = 0;
  int tail = 0;
  int nbits = 0;
  logic [15:0] word = 16'h0000;
  logic sclk_q = 1'b0;
  logic sync_q = 1'b0;

  initial begin
    o_convert_start_n = 1'b1;
    o_clk = 1'b0;
  end

  // Frame capture on sampled edges of the master clock
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    sclk_q <= i_sclk;
    sync_q <= i_sync;
    if (i_sync && !sync_q) begin
      t_sync <= cyc;
      nbits <= 0;
      per <= 999;
      t_rise <= -1;
    end
    if (i_sync && i_sclk && !sclk_q) begin
      word <= {word[14:0], i_sdo};
      nbits <= nbits + 1;
      if (t_rise < 0) lead <= cyc - t_sync;
      else if (cyc - t_rise < per) per <= cyc - t_rise;
      t_rise <= cyc;
    end
    if (!i_sclk && sclk_q) t_fall <= cyc;
    if (!i_sync && sync_q) tail <= cyc - t_fall;
  end

  // One sampled edge low is 25 ns; the bench spaces starts and waits out busy
  task start_pulse;
    @(posedge i_mclk) o_convert_start_n <= 1'b0;
    @(posedge i_mclk) o_convert_start_n <= 1'b1;
  endtask

  // Clock high and low two cycles each, clock still outside the frame
  task slave_read(output logic [15:0] w);
    @(posedge i_mclk);
    for (int i = 0; i < 16; i++) begin
      w = {w[14:0], i_sdo};
      o_clk <= 1'b1;
      repeat (2) @(posedge i_mclk);
      o_clk <= 1'b0;
      repeat (2) @(posedge i_mclk);
    end
  endtask
endmodule

`default_nettype wire

// [test_adc_conversion_readout_timing.sv]
/*
  Self-checking bench: register access, parallel, master and slave serial
  readout timing. Assumes adcr_host_model as the far side.
*/
`include "adcr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module test_adc_conversion_readout_timing;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic cs_n = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic [15:0] sample = 16'h0000;
  logic [15:0] pdata, d_pre, w, prev;
  logic ack, busy, data_oe, sclk, sclk_oe, sync, sync_oe, sdo, sdo_oe;
  logic start_n, host_clk, sclk_w, sync_w, sdo_w;
  logic sdo_last = 1'b0;
  logic [31:0] seed = 32'h9000;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int t_bh, t_sy, t_syf, t_bf, n;

  assign sclk_w = sclk_oe ? sclk : host_clk;
  assign sync_w = sync_oe ? sync : 1'b0;
  assign sdo_w = sdo_oe ? sdo : ~sdo_last;

  adcr_core dut (.i_mclk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_convert_start_n(start_n), .i_cs_n(cs_n), .i_sample_data(sample), .o_busy(busy),
    .o_data(pdata), .o_data_oe(data_oe), .i_serial_data_clock(sclk_w),
    .o_serial_data_clock(sclk), .o_serial_data_clock_oe(sclk_oe), .o_frame_sync(sync),
    .o_frame_sync_oe(sync_oe), .o_serial_data_out(sdo), .o_serial_data_out_oe(sdo_oe));

  adcr_host_model host (.i_mclk(clk), .i_sync(sync_w), .i_sclk(sclk_w), .i_sdo(sdo_w),
    .o_convert_start_n(start_n), .o_clk(host_clk));

  initial forever #12.5 clk = ~clk;

  always @(posedge clk) begin
    sdo_last <= sdo_w;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      wrap_up;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  function automatic int min_per(input int d);
    return (d == 0) ? 2 : (d == 1) ? 3 : (d == 2) ? 5 : 10;
  endfunction

  function automatic int busy_max(input int d);
    return (d == 0) ? 90 : (d == 1) ? 120 : (d == 2) ? 176 : 292;
  endfunction

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task wb(input logic w_en, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_en;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  // Start one conversion and stamp busy and sync in cycles after the start edge
  task conv(input logic [15:0] s);
    @(posedge clk) sample <= s;
    host.start_pulse;
    t_bh = 0;
    t_sy = 0;
    t_syf = 0;
    t_bf = 0;
    for (n = 1; n < 400 && t_bf == 0; n++) begin
      @(posedge clk);
      if (busy === 1'b1 && t_bh == 0) t_bh = n;
      if (sync_w === 1'b1 && t_sy == 0) t_sy = n;
      if (sync_w !== 1'b1 && t_sy != 0 && t_syf == 0) t_syf = n;
      if (busy !== 1'b1 && t_bh != 0) t_bf = n;
      else d_pre = pdata;
    end
    repeat (110) @(posedge clk);
  endtask

  task wrap_up;
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(`ADCR_OFS_CTRL, 32'h0);
    rd(`ADCR_OFS_STATUS, 32'h0);
    rd(`ADCR_OFS_RESULT, 32'h0);
    rd(4'hC, 32'h0);
    chk(32'(data_oe), 32'h1);
    @(posedge clk) cs_n <= 1'b1;
    @(posedge clk) cs_n <= 1'b0;
    chk({data_oe, sclk_oe, sync_oe, sdo_oe}, 32'h0);
    // Parallel: all-ones, all-zeros, then random words
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      prev = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : seed[15:0];
      conv(prev);
      chk(32'(t_bh), 32'h1);
      chk(32'(t_bf - t_bh <= 58), 32'h1);
      chk(32'(t_bf <= 57), 32'h1);
      chk(32'(d_pre), 32'(prev));
      rd(`ADCR_OFS_RESULT, 32'(prev));
    end
    // Master read after convert, every divide code
    for (int d = 0; d < 4; d++) begin
      wb(1'b1, `ADCR_OFS_CTRL, 32'(d << 4) | 32'h1);
      seed = xs(seed);
      prev = (d == 0) ? 16'h8001 : seed[15:0];
      conv(prev);
      chk(32'(host.word), 32'(prev));
      chk(32'(host.nbits), 32'h10);
      chk(32'(t_sy >= 51 && t_sy <= 55), 32'h1);
      chk(32'(host.per >= min_per(d)), 32'h1);
      chk(32'(t_bf - t_bh <= busy_max(d)), 32'h1);
      chk(32'(host.lead >= 1), 32'h1);
      chk(32'(host.tail >= 1), 32'h1);
      chk(32'(t_bf - t_syf), 32'h1);
      chk({data_oe, sclk_oe, sync_oe, sdo_oe}, 32'h7);
    end
    // Chip select high floats the master serial pins
    @(posedge clk) cs_n <= 1'b1;
    @(posedge clk) chk({sclk_oe, sync_oe, sdo_oe}, 32'h0);
    cs_n <= 1'b0;
    // Master read during convert with divide code 3 set
    wb(1'b1, `ADCR_OFS_CTRL, 32'h35);
    seed = xs(seed);
    conv(seed[15:0]);
    chk(32'(host.word), 32'(prev));
    chk(32'(t_sy >= 21 && t_sy <= 25), 32'h1);
    chk(32'(host.per), 32'h2);
    chk(32'(t_bf - t_bh <= 58), 32'h1);
    prev = seed[15:0];
    // Status flags read while converting with the frame running
    host.start_pulse;
    repeat (25) @(posedge clk);
    rd(`ADCR_OFS_STATUS, 32'h3);
    repeat (200) @(posedge clk);
    chk(32'(host.word), 32'(prev));
    // Slave serial: host clocks the word out
    wb(1'b1, `ADCR_OFS_CTRL, 32'h3);
    seed = xs(seed);
    conv(seed[15:0]);
    chk({sclk_oe, sdo_oe}, 32'h1);
    host.slave_read(w);
    chk(32'(w), 32'(seed[15:0]));
    wb(1'b1, 4'hC, 32'hFF);
    rd(`ADCR_OFS_CTRL, 32'h3);
    wrap_up;
  end
endmodule

`default_nettype wire
